// [verilog/npe_ctrl.v]
// feature registers, write protection and ecc steering of the serial nand
// assumes an external bch codec and array sequencer on clk_i
// Operation
// - ecc enable set at power-up and reset
// - host writes ecc enable via set feature
// - program path stores computed check bytes
// - read decode result shown in ecc field
// - erased page always reports ecc zero
// - host check-byte writes replaced while ecc on
// - main area is four 512-byte sectors
// - spare groups: 3 metadata, 13 check bytes
// - protection register at A0, read/write features
// - range bits all one after power-up
// - lock bit and low wp ignore writes
// - protected program/erase refused, fail flag set
// - 000 none, 111 all, else top fractions
// - low side or complement alone lower ranges, both together upper, but complement with 110 locks block 0 only
// - ecc result codes ok, fixed, bad, eight
`timescale 1ns/1ps
`default_nettype none
`include "npe_consts.vh"

module npe_ctrl #(
  parameter PAGE_W = 17
) (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // serial pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire si_i,
  input wire wp_n_i,
  output reg so_o,
  output wire so_oe_o,
  // sequencer status
  input wire wel_i,
  input wire oip_i,
  // program and erase requests
  input wire prog_req_i,
  input wire erase_req_i,
  input wire [PAGE_W-1:0] op_page_i,
  output reg prog_go_o,
  output reg erase_go_o,
  // program byte stream toward array
  input wire pgm_valid_i,
  input wire [11:0] pgm_addr_i,
  input wire [7:0] pgm_data_i,
  input wire [7:0] ecc_code_i,
  output reg arr_valid_o,
  output reg [11:0] arr_addr_o,
  output reg [7:0] arr_data_o,
  output reg ecc_feed_o,
  output reg [1:0] ecc_sector_o,
  // read decode results
  input wire rd_start_i,
  input wire rd_done_i,
  input wire rd_erased_i,
  input wire rd_uncorr_i,
  input wire rd_eight_i,
  input wire rd_corr_i,
  // configuration
  output wire ecc_en_o,
  output wire reset_cmd_o
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire [3:0] pin_raw;
  wire [3:0] pin_st;
  wire [3:0] pin_rise;
  wire [3:0] pin_fall;
  assign pin_raw = {wp_n_i, si_i, cs_n_i, sclk_i};

  // stages start at each pin's idle level so no false edge follows reset
  localparam [3:0] PIN_IDLE = `NPE_PIN_IDLE;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      reg s1, s2, s3, st;
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1 <= PIN_IDLE[g];
          s2 <= PIN_IDLE[g];
          s3 <= PIN_IDLE[g];
          st <= PIN_IDLE[g];
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            st <= s3;
          end
        end
      end
      assign pin_st[g] = st;
      assign pin_rise[g] = (s2 == s3) && s3 && !st;
      assign pin_fall[g] = (s2 == s3) && !s3 && st;
    end
  endgenerate

  wire sclk_rise = pin_rise[0];
  wire sclk_fall = pin_fall[0];
  wire cs_n = pin_st[1];
  wire si = pin_st[2];
  wire wp_n = pin_st[3];

  // ************************************************************
  // serial frame decoder
  // ************************************************************
  reg [4:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] cmd;
  reg [7:0] faddr;
  reg [7:0] tx;
  reg reset_cmd;
  reg wr_strobe;
  reg [7:0] wr_data;
  wire [7:0] next_byte = {shift[6:0], si};
  reg [7:0] rdata;
  reg [7:0] protect;
  reg ecc_en;
  reg [1:0] ecc_res;
  reg p_fail;
  reg e_fail;

  // feature read multiplexer
  always @* begin
    case (next_byte)
      `NPE_FA_PROTECT: rdata = protect;
      `NPE_FA_CONFIG: rdata = {3'h0, ecc_en, 4'h0};
      `NPE_FA_STATUS: rdata = {2'h0, ecc_res, p_fail, e_fail, wel_i, oip_i};
      default: rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= 5'h00;
      shift <= 8'h00;
      cmd <= 8'h00;
      faddr <= 8'h00;
      tx <= 8'h00;
      reset_cmd <= 1'b0;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      reset_cmd <= 1'b0;
      wr_strobe <= 1'b0;
      if (cs_n) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        shift <= next_byte;
        if (bit_cnt != `NPE_CNT_MAX) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
        if (bit_cnt == `NPE_CNT_CMD) begin
          cmd <= next_byte;
          reset_cmd <= (next_byte == `NPE_CMD_RESET);
        end
        if (bit_cnt == `NPE_CNT_ADDR) begin
          faddr <= next_byte;
          tx <= rdata;
        end
        if (bit_cnt == `NPE_CNT_WR && cmd == `NPE_CMD_SET) begin
          wr_strobe <= 1'b1;
          wr_data <= next_byte;
        end
      end else if (sclk_fall && bit_cnt > `NPE_CNT_DATA) begin
        tx <= {tx[6:0], tx[7]};
      end
    end
  end

  wire reading = !cs_n && cmd == `NPE_CMD_GET && bit_cnt >= `NPE_CNT_DATA;
  assign so_oe_o = reading;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      so_o <= 1'b0;
    end else begin
      so_o <= reading ? tx[7] : 1'b0;
    end
  end

  // ************************************************************
  // feature registers
  // ************************************************************
  wire prot_frozen = protect[`NPE_PROT_LOCK] && !wp_n;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      protect <= `NPE_PROT_RESET;
      ecc_en <= 1'b1;
    end else if (reset_cmd) begin
      ecc_en <= 1'b1;
    end else if (wr_strobe) begin
      if (faddr == `NPE_FA_PROTECT && !prot_frozen) begin
        protect <= wr_data & `NPE_PROT_WMASK;
      end
      if (faddr == `NPE_FA_CONFIG) begin
        ecc_en <= wr_data[`NPE_CFG_ECC_EN];
      end
    end
  end

  assign ecc_en_o = ecc_en;
  assign reset_cmd_o = reset_cmd;

  // ************************************************************
  // protection check for program and erase
  // ************************************************************
  wire op_locked;

  npe_range_decode #(
    .PAGE_W(PAGE_W)
  ) u_range (
    .range_i(protect[`NPE_PROT_BP_HI:`NPE_PROT_BP_LO]),
    .low_side_i(protect[`NPE_PROT_LOW]),
    .complement_i(protect[`NPE_PROT_COMPL]),
    .page_i(op_page_i),
    .locked_o(op_locked)
  );

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      p_fail <= 1'b0;
      e_fail <= 1'b0;
      prog_go_o <= 1'b0;
      erase_go_o <= 1'b0;
    end else begin
      prog_go_o <= prog_req_i && !op_locked;
      erase_go_o <= erase_req_i && !op_locked;
      if (prog_req_i) begin
        p_fail <= op_locked;
      end else if (reset_cmd) begin
        p_fail <= 1'b0;
      end
      if (erase_req_i) begin
        e_fail <= op_locked;
      end else if (reset_cmd) begin
        e_fail <= 1'b0;
      end
    end
  end

  // ************************************************************
  // program stream: sector tagging and check-byte substitution
  // ************************************************************
  wire in_spare = pgm_addr_i[`NPE_SPARE_BIT];
  wire is_chk = in_spare && pgm_addr_i[3:0] >= `NPE_GRP_CHK_FIRST;
  wire bbm_byte = pgm_addr_i == `NPE_BBM_ADDR; // mark byte is plain metadata

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arr_valid_o <= 1'b0;
      arr_addr_o <= 12'h000;
      arr_data_o <= 8'h00;
      ecc_feed_o <= 1'b0;
      ecc_sector_o <= 2'h0;
    end else begin
      arr_valid_o <= pgm_valid_i;
      ecc_feed_o <= pgm_valid_i && ecc_en && (!is_chk || bbm_byte);
      if (pgm_valid_i) begin
        arr_addr_o <= pgm_addr_i;
        // main sectors by bits 10:9, spare groups by bits 5:4
        ecc_sector_o <= in_spare ? pgm_addr_i[5:4] : pgm_addr_i[10:9];
        arr_data_o <= (ecc_en && is_chk) ? ecc_code_i : pgm_data_i;
      end
    end
  end

  // ************************************************************
  // read decode result
  // ************************************************************
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ecc_res <= `NPE_ECC_OK;
    end else if (rd_done_i) begin
      if (rd_erased_i || !ecc_en) begin
        ecc_res <= `NPE_ECC_OK;
      end else if (rd_uncorr_i) begin
        ecc_res <= `NPE_ECC_UNCORR;
      end else if (rd_eight_i) begin
        ecc_res <= `NPE_ECC_EIGHT;
      end else if (rd_corr_i) begin
        ecc_res <= `NPE_ECC_CORR;
      end else begin
        ecc_res <= `NPE_ECC_OK;
      end
    end else if (rd_start_i) begin
      ecc_res <= `NPE_ECC_OK;
    end
  end

endmodule
`default_nettype wire

// [verilog/npe_consts.vh]
// constants for the nand protection and ecc control block
// assumes inclusion by bare name from the design files
`ifndef NPE_CONSTS_VH
`define NPE_CONSTS_VH

// ************************************************************
// serial commands and feature addresses
// ************************************************************
`define NPE_CMD_GET 8'h0F
`define NPE_CMD_SET 8'h1F
`define NPE_CMD_RESET 8'hFF
`define NPE_FA_PROTECT 8'hA0
`define NPE_FA_CONFIG 8'hB0
`define NPE_FA_STATUS 8'hC0

// ************************************************************
// frame bit counts
// ************************************************************
`define NPE_CNT_CMD 5'h07
`define NPE_CNT_ADDR 5'h0F
`define NPE_CNT_DATA 5'h10
`define NPE_CNT_WR 5'h17
`define NPE_CNT_MAX 5'h1F

// ************************************************************
// protection register layout and reset value
// ************************************************************
`define NPE_PROT_RESET 8'h38
`define NPE_PROT_WMASK 8'hBE
`define NPE_PROT_LOCK 7
`define NPE_PROT_BP_HI 5
`define NPE_PROT_BP_LO 3
`define NPE_PROT_LOW 2
`define NPE_PROT_COMPL 1

// ************************************************************
// configuration and status layout
// ************************************************************
`define NPE_CFG_ECC_EN 4
`define NPE_ST_ECC_HI 5
`define NPE_ST_ECC_LO 4
`define NPE_ST_PFAIL 3
`define NPE_ST_EFAIL 2
`define NPE_ST_WEL 1
`define NPE_ST_OIP 0

// ************************************************************
// pin idle levels: wp_n, si, cs_n high, sclk low
// ************************************************************
`define NPE_PIN_IDLE 4'hE

// ************************************************************
// ecc result codes
// ************************************************************
`define NPE_ECC_OK 2'h0
`define NPE_ECC_CORR 2'h1
`define NPE_ECC_UNCORR 2'h2
`define NPE_ECC_EIGHT 2'h3

// ************************************************************
// page layout
// ************************************************************
`define NPE_SPARE_BIT 11
`define NPE_GRP_CHK_FIRST 4'h3
`define NPE_BBM_ADDR 12'h800
`define NPE_BBM_GOOD 8'hFF
`define NPE_RANGE_NONE 3'h0
`define NPE_RANGE_ALL 3'h7
`define NPE_RANGE_B0 3'h6
`define NPE_BLK_PAGE_W 6

`endif

// [verilog/npe_range_decode.v]
// protected page range decoder
// assumes a stable page address and protection bits from the same clock
`timescale 1ns/1ps
`default_nettype none
`include "npe_consts.vh"

module npe_range_decode #(
  parameter PAGE_W = 17
) (
  // protection bits
  input wire [2:0] range_i,
  input wire low_side_i,
  input wire complement_i,
  // page under test
  input wire [PAGE_W-1:0] page_i,
  // result
  output reg locked_o
);

  wire [5:0] top6;
  reg [5:0] mask;
  wire all_one;
  wire all_zero;
  wire blk0;

  assign top6 = page_i[PAGE_W-1:PAGE_W-6];
  assign all_one = &(top6 | ~mask);
  assign all_zero = ~|(top6 & mask);
  assign blk0 = ~|page_i[PAGE_W-1:`NPE_BLK_PAGE_W];

  // top bits compared: code n looks at 7-n leading bits
  always @* begin
    case (range_i)
      3'h1: mask = 6'h3F;
      3'h2: mask = 6'h3E;
      3'h3: mask = 6'h3C;
      3'h4: mask = 6'h38;
      3'h5: mask = 6'h30;
      3'h6: mask = 6'h20;
      default: mask = 6'h00;
    endcase
  end

  always @* begin
    if (range_i == `NPE_RANGE_NONE) begin
      locked_o = 1'b0;
    end else if (range_i == `NPE_RANGE_ALL) begin
      locked_o = 1'b1;
    end else if (!complement_i && !low_side_i) begin
      locked_o = all_one;
    end else if (!complement_i) begin
      locked_o = all_zero;
    end else if (range_i == `NPE_RANGE_B0) begin
      locked_o = blk0;
    end else if (!low_side_i) begin
      locked_o = ~all_one;
    end else begin
      locked_o = ~all_zero;
    end
  end

endmodule
`default_nettype wire

// [verif/npe_ctrl_assertions.sv]
// checker for the nand protection and ecc control block
// assumes it is bound onto npe_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module npe_ctrl_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // serial, requests and config
  input wire logic cs_n_i,
  input wire logic so_oe_o,
  input wire logic prog_req_i,
  input wire logic erase_req_i,
  input wire logic prog_go_o,
  input wire logic erase_go_o,
  input wire logic reset_cmd_o,
  input wire logic ecc_en_o,
  // program stream
  input wire logic pgm_valid_i,
  input wire logic [11:0] pgm_addr_i,
  input wire logic [7:0] pgm_data_i,
  input wire logic [7:0] ecc_code_i,
  input wire logic arr_valid_o,
  input wire logic [11:0] arr_addr_o,
  input wire logic [7:0] arr_data_o,
  input wire logic ecc_feed_o,
  input wire logic [1:0] ecc_sector_o
);
  // ********
  // properties
  // ********
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire chk_col = pgm_addr_i[11] && (pgm_addr_i[3:0] >= 4'h3);
  wire feed_exp = pgm_valid_i && ecc_en_o && !chk_col;
  wire [1:0] sec_exp = pgm_addr_i[11] ? pgm_addr_i[5:4] : pgm_addr_i[10:9];
  wire [7:0] byte_exp = (ecc_en_o && chk_col) ? ecc_code_i : pgm_data_i;
  AST_ARR_VALID: assert property (arr_valid_o == $past(pgm_valid_i))
    else $error("array strobe not one cycle after byte");
  AST_ARR_ADDR: assert property (pgm_valid_i |=> arr_addr_o == $past(pgm_addr_i))
    else $error("array column wrong");
  AST_ARR_DATA: assert property (pgm_valid_i |=> arr_data_o == $past(byte_exp))
    else $error("array byte wrong");
  AST_FEED: assert property (ecc_feed_o == $past(feed_exp))
    else $error("codec feed wrong");
  AST_SECTOR: assert property (pgm_valid_i |=> ecc_sector_o == $past(sec_exp))
    else $error("sector wrong");
  AST_PROG_GO: assert property (prog_go_o |-> $past(prog_req_i))
    else $error("program start without request");
  AST_ERASE_GO: assert property (erase_go_o |-> $past(erase_req_i))
    else $error("erase start without request");
  AST_OE_IDLE: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("output driven while deselected");
  AST_RST_ECC: assert property (reset_cmd_o |-> ##[0:2] ecc_en_o)
    else $error("reset command left ecc off");
  cover property (prog_req_i ##1 !prog_go_o);
  cover property (pgm_valid_i && chk_col && ecc_en_o);
  cover property (so_oe_o ##1 cs_n_i);
endmodule
bind npe_ctrl npe_ctrl_assertions u_npe_ctrl_assertions (
  .clk_i, .resetn_i, .cs_n_i, .so_oe_o, .prog_req_i, .erase_req_i, .prog_go_o,
  .erase_go_o, .reset_cmd_o, .ecc_en_o, .pgm_valid_i, .pgm_addr_i, .pgm_data_i,
  .ecc_code_i, .arr_valid_o, .arr_addr_o, .arr_data_o, .ecc_feed_o, .ecc_sector_o
);
`default_nettype wire

// [verif/npe_host_model.sv]
// serial host model sending 24-bit feature frames in mode 0
// assumes the bench calls xfer and drives nothing on the serial pins
`timescale 1ns/1ps
`default_nettype none
module npe_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  input wire logic so_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  // ********
  // frame engine
  // ********
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b1;
  end
  task automatic xfer(input logic [23:0] f, output logic [7:0] rd);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      si_o = f[i];
      repeat (5) @(negedge clk_i);
      sclk_o = 1'b1;
      if (i < 8) rd = {rd[6:0], so_i};
      repeat (5) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    // released line has no pull, so it must not keep the last bit
    si_o = ~si_o;
    repeat (5) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// [verif/npe_ctrl_test.sv]
// self-checking bench for npe_ctrl
// assumes the host model on the serial pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
module npe_ctrl_test;
  logic clk_i, resetn_i, sclk_i, cs_n_i, si_i, wp_n_i, so_o, so_oe_o, wel_i, oip_i;
  logic prog_req_i, erase_req_i, prog_go_o, erase_go_o, pgm_valid_i, arr_valid_o;
  logic rd_start_i, rd_done_i, rd_erased_i, rd_uncorr_i, rd_eight_i, rd_corr_i;
  logic ecc_feed_o, ecc_en_o, reset_cmd_o;
  logic [16:0] op_page_i;
  logic [11:0] pgm_addr_i, arr_addr_o;
  logic [7:0] pgm_data_i, ecc_code_i, arr_data_o;
  logic [1:0] ecc_sector_o;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  npe_ctrl #(.PAGE_W(17)) u_npe_ctrl (.clk_i, .resetn_i, .sclk_i, .cs_n_i, .si_i,
    .wp_n_i, .so_o, .so_oe_o, .wel_i, .oip_i, .prog_req_i, .erase_req_i, .op_page_i,
    .prog_go_o, .erase_go_o, .pgm_valid_i, .pgm_addr_i, .pgm_data_i, .ecc_code_i,
    .arr_valid_o, .arr_addr_o, .arr_data_o, .ecc_feed_o, .ecc_sector_o, .rd_start_i,
    .rd_done_i, .rd_erased_i, .rd_uncorr_i, .rd_eight_i, .rd_corr_i, .ecc_en_o,
    .reset_cmd_o);
  npe_host_model u_npe_host_model (.clk_i, .so_i(so_o), .sclk_o(sclk_i),
    .cs_n_o(cs_n_i), .si_o(si_i));
  // ********
  // helpers
  // ********
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  task automatic conclude;
    $display("errors=%0d tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_npe_host_model.xfer({8'h1F, a, d}, r);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    u_npe_host_model.xfer({8'h0F, a, 8'h00}, r);
    chk(r, e);
  endtask
  function automatic logic lk(input int m, input int c, input int p);
    int s;
    s = 1 << (10 + c);
    if (c == 0 || c == 7) return c == 7;
    if (m % 2 == 1 && c == 6) return p < 64;
    case (m)
      0: return p >= 131072 - s;
      1: return p < 131072 - s;
      2: return p < s;
      default: return p >= s;
    endcase
  endfunction
  task automatic op(input logic [16:0] p, input logic l);
    op_page_i = p;
    prog_req_i = 1'b1;
    @(negedge clk_i);
    prog_req_i = 1'b0;
    erase_req_i = 1'b1;
    chk(8'(prog_go_o), 8'(!l));
    @(negedge clk_i);
    erase_req_i = 1'b0;
    chk(8'(erase_go_o), 8'(!l));
  endtask
  task automatic pg(input logic [11:0] a, input logic c, input logic f, input logic [1:0] s);
    pgm_addr_i = a;
    pgm_data_i = a[7:0];
    ecc_code_i = ~a[7:0];
    pgm_valid_i = 1'b1;
    @(negedge clk_i);
    chk(arr_data_o, c ? ~a[7:0] : a[7:0]);
    chk(8'(ecc_feed_o), 8'(f));
    chk(8'(ecc_sector_o), 8'(s));
    chk(8'(arr_valid_o), 8'h01);
    chk(arr_addr_o[11:4], a[11:4]);
    chk(8'(arr_addr_o[3:0]), 8'(a[3:0]));
  endtask
  task automatic rres(input logic [3:0] fl, input logic [7:0] e);
    rd_start_i = 1'b1;
    @(negedge clk_i);
    rd_start_i = 1'b0;
    {rd_erased_i, rd_uncorr_i, rd_eight_i, rd_corr_i} = fl;
    rd_done_i = 1'b1;
    @(negedge clk_i);
    rd_done_i = 1'b0;
    rchk(8'hC0, e);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset;
    chk(8'(ecc_en_o), 8'h01);
    rchk(8'hB0, 8'h10);
    rchk(8'hA0, 8'h38);
    rchk(8'h90, 8'h00);
    chk(8'(so_oe_o), 8'h00);
  endtask
  task automatic t_ecc;
    logic [7:0] r;
    wr(8'hB0, 8'h00);
    chk(8'(ecc_en_o), 8'h00);
    wr(8'hB0, 8'hFF);
    rchk(8'hB0, 8'h10);
    wr(8'hB0, 8'h00);
    u_npe_host_model.xfer(24'hFF0000, r);
    chk(8'(ecc_en_o), 8'h01);
  endtask
  task automatic t_prot;
    wr(8'hA0, 8'hFF);
    rchk(8'hA0, 8'hBE);
    wp_n_i = 1'b0;
    wr(8'hA0, 8'h00);
    rchk(8'hA0, 8'hBE);
    wp_n_i = 1'b1;
    wr(8'hA0, 8'h00);
    rchk(8'hA0, 8'h00);
  endtask
  task automatic t_range;
    int b;
    logic [16:0] p [4];
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 8; c++) begin
        b = m[1] ? 1 << (10 + c) : 131072 - (1 << (10 + c));
        wr(8'hA0, 8'(c * 8 + m * 2));
        p = '{17'(b - 1), 17'(b), 17'h0003F, 17'h00040};
        foreach (p[i]) op(p[i], lk(m, c, p[i]));
      end
    rchk(8'hC0, 8'h0C);
    wel_i = 1'b1;
    oip_i = 1'b1;
    wr(8'hA0, 8'h00);
    op(17'h00000, 1'b0);
    rchk(8'hC0, 8'h03);
    wel_i = 1'b0;
    oip_i = 1'b0;
  endtask
  task automatic t_stream;
    pg(12'h000, 1'b0, 1'b1, 2'h0);
    pg(12'h7FF, 1'b0, 1'b1, 2'h3);
    pg(12'h800, 1'b0, 1'b1, 2'h0);
    pg(12'h812, 1'b0, 1'b1, 2'h1);
    pg(12'h813, 1'b1, 1'b0, 2'h1);
    pg(12'h83F, 1'b1, 1'b0, 2'h3);
    pgm_valid_i = 1'b0;
    wr(8'hB0, 8'h00);
    pg(12'h823, 1'b0, 1'b0, 2'h2);
    pgm_valid_i = 1'b0;
  endtask
  task automatic t_read;
    rres(4'h1, 8'h00);
    rres(4'h4, 8'h00);
    wr(8'hB0, 8'h10);
    rres(4'h1, 8'h10);
    rres(4'h3, 8'h30);
    rres(4'h7, 8'h20);
    rres(4'h0, 8'h00);
    rres(4'hC, 8'h00);
  endtask
  initial begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    {wp_n_i, wel_i, oip_i, prog_req_i, erase_req_i, pgm_valid_i} = 6'h20;
    {rd_start_i, rd_done_i, rd_erased_i, rd_uncorr_i, rd_eight_i, rd_corr_i} = 6'h00;
    op_page_i = 17'h00000;
    pgm_addr_i = 12'h000;
    pgm_data_i = 8'h00;
    ecc_code_i = 8'h00;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_reset;
    t_ecc;
    t_prot;
    t_range;
    t_stream;
    t_read;
    conclude;
  end
endmodule
`default_nettype wire
